// [bench/lse_mem_model.sv]
// memory model answering the exec unit's operand requests
`timescale 1ns/10ps
module lse_mem_model (
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire lse_pkg::lse_mem_req_t REQ,
  output lse_pkg::lse_mem_rsp_t      RSP
);
  import lse_pkg::*;
  logic [DW-1:0] mem [0:255];  // word store on low address bits
  logic [1:0]    wait_reg;     // cycles still to wait
  logic          slow_reg;     // alternates prompt and slow answers
  logic          req_on;       // a request is held
  logic          hit;          // answer in this cycle
  assign req_on = REQ.rd || REQ.wr;
  assign hit = req_on && !RSP.ack && (wait_reg == 2'h0);
  // ack pulse with data; data line wanders while idle
  always_ff @(posedge CLK) begin
    if (RST) begin
      RSP      <= '0;
      wait_reg <= 2'h0;
      slow_reg <= 1'b0;
    end else if (hit) begin
      RSP      <= {1'b1, mem[REQ.addr[7:0]]};
      slow_reg <= !slow_reg;
      wait_reg <= {slow_reg, 1'b0};
    end else begin
      RSP <= {1'b0, ~RSP.rdata};
      if (req_on && wait_reg != 2'h0) begin
        wait_reg <= wait_reg - 2'h1;
      end
    end
  end
  // write on ack; plain always so the bench may preload words
  always @(posedge CLK) begin
    if (hit && REQ.wr) begin
      mem[REQ.addr[7:0]] <= REQ.wdata;
    end
  end
endmodule

// [bench/testbench.sv]
// bench driving the exec unit over its register bus
`timescale 1ns/10ps
module testbench;
  import lse_pkg::*;
  logic         ref_clk = 1'b0;   // 100 MHz clock
  logic         srst = 1'b1;      // held for six cycles
  logic [7:0]   avs_address = 8'h00;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  lse_mem_req_t mem_req;
  lse_mem_rsp_t mem_rsp;
  logic         busy;             // busy pin
  logic         ovf;              // overflow pin
  int           failures = 0;
  int           check_count = 0;
  always #5 ref_clk = ~ref_clk;
  lse_exec_unit #(.MAX_INDIRECT(2)) DUT (.REF_CLK(ref_clk), .SRST(srst),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .MEM_REQ(mem_req), .MEM_RSP(mem_rsp), .BUSY(busy),
    .OVERFLOW_FLAG(ovf));
  lse_mem_model mem_model (.CLK(ref_clk), .RST(srst), .REQ(mem_req), .RSP(mem_rsp));
  // verdict and end of run
  task automatic summarize();
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // word comparison
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus access, held until waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) failures++;
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // load registers, start, poll until idle
  task automatic run_op(input logic [15:0] w1, w2, a, b);
    logic [15:0] q;
    int n;
    n = 0;
    bus(1'b1, OFS_ACC, a, q);
    bus(1'b1, OFS_EXT, b, q);
    bus(1'b1, OFS_WORD1, w1, q);
    bus(1'b1, OFS_WORD2, w2, q);
    bus(1'b1, OFS_PADDR, 16'h0020, q);
    bus(1'b1, OFS_STATUS, 16'h0006, q);
    bus(1'b1, OFS_CTRL, 16'h0001, q);
    do begin
      bus(1'b0, OFS_STATUS, 16'h0000, q);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 200);
    if (n >= 200) failures++;
  endtask
  // read back registers and overflow
  task automatic chk(input logic [15:0] ea, eb, ex, input logic eof);
    logic [15:0] q;
    bus(1'b0, OFS_ACC, 16'h0000, q);
    cmp(q, ea);
    bus(1'b0, OFS_EXT, 16'h0000, q);
    cmp(q, eb);
    bus(1'b0, OFS_IDX, 16'h0000, q);
    cmp(q, ex);
    bus(1'b0, OFS_STATUS, 16'h0000, q);
    cmp(q & 16'h0002, {14'h0, eof, 1'b0});
    cmp({14'h0, busy, ovf}, {15'h0, eof});
  endtask
  function automatic logic [15:0] two(input logic [3:0] c, input logic [2:0] m);
    return {TWO_PAT, 2'b00, c, m};
  endfunction
  logic [3:0]  lcode [3] = '{FN_OR, FN_XOR, FN_AND};
  logic [15:0] lres [3] = '{16'hFFF0, 16'h0FF0, 16'hF000};
  logic [15:0] q;
  initial begin
    mem_model.mem[8'h10] = 16'h7FFF;
    mem_model.mem[8'h20] = 16'h0005;
    mem_model.mem[8'h40] = 16'h4321;
    mem_model.mem[8'h50] = 16'h0040;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    run_op(two(FN_LDA, MODE_IMM), 16'h1234, 16'h0000, 16'h0000);
    chk(16'h1234, 16'h0000, 16'h0000, 1'b0);
    run_op(two(FN_LDB, MODE_IMM), 16'h5678, 16'h1234, 16'h0000);
    chk(16'h1234, 16'h5678, 16'h0000, 1'b0);
    run_op(two(FN_LDX, MODE_IMM), 16'h9ABC, 16'h1234, 16'h5678);
    chk(16'h1234, 16'h5678, 16'h9ABC, 1'b0);
    run_op(two(FN_INC, MODE_IMM), 16'h0005, 16'h0000, 16'h0000);
    cmp(mem_model.mem[8'h20], 16'h0006);
    run_op(two(FN_STA, MODE_IMM), 16'h0006, 16'hBEEF, 16'h0001);
    chk(16'hBEEF, 16'h0001, 16'h9ABC, 1'b0);
    cmp(mem_model.mem[8'h20], 16'hBEEF);
    run_op(two(FN_STX, 3'h1), 16'h0030, 16'h0000, 16'h0000);
    cmp(mem_model.mem[8'h30], 16'h9ABC);
    run_op(two(FN_LDX, 3'h1), 16'h0040, 16'h0000, 16'h0000);
    chk(16'h0000, 16'h0000, 16'h4321, 1'b0);
    run_op(two(FN_LDA, MODE_REL), 16'h0020, 16'h0000, 16'h0000);
    chk(16'h4321, 16'h0000, 16'h4321, 1'b0);
    run_op(16'h4010, 16'h0000, 16'h0000, 16'h0000);
    cmp(mem_model.mem[8'h10], MOST_NEG);
    chk(16'h0000, 16'h0000, 16'h4321, 1'b1);
    run_op(two(FN_ADD, MODE_IMM), 16'h0002, MAX_POS, 16'h0000);
    chk(16'h8001, 16'h0000, 16'h4321, 1'b1);
    run_op(two(FN_SUB, MODE_IMM), 16'h0001, MOST_NEG, 16'h0000);
    chk(MAX_POS, 16'h0000, 16'h4321, 1'b1);
    run_op(two(FN_MUL, MODE_IMM), 16'h0005, 16'h0002, 16'h0003);
    chk(16'h0000, 16'h0011, 16'h4321, 1'b0);
    run_op(two(FN_MUL, MODE_IMM), MOST_NEG, 16'h0000, MOST_NEG);
    chk(16'h8000, 16'h0000, 16'h4321, 1'b1);
    run_op(two(FN_DIV, MODE_IMM), 16'h0002, 16'h0000, 16'h0007);
    chk(16'h0001, 16'h0003, 16'h4321, 1'b0);
    run_op(two(FN_DIV, MODE_IMM), 16'h0007, 16'h0000, 16'h0003);
    chk(16'h0003, 16'h0000, 16'h4321, 1'b0);
    for (int i = 0; i < 3; i++) begin
      run_op(two(lcode[i], MODE_IMM), 16'hFF00, 16'hF0F0, 16'h0000);
      chk(lres[i], 16'h0000, 16'h4321, 1'b0);
    end
    run_op({FN_OR, 12'h040}, 16'h0000, 16'hF0F0, 16'h0000);
    chk(16'hF3F1, 16'h0000, 16'h4321, 1'b0);
    run_op(16'h1E50, 16'h0000, 16'h0000, 16'h0000);
    chk(16'h4321, 16'h0000, 16'h4321, 1'b0);
    run_op(two(FN_STA, MODE_XIX), 16'h0020, 16'h1357, 16'h0000);
    cmp(mem_model.mem[8'h41], 16'h1357);
    bus(1'b0, 8'h40, 16'h0000, q);
    cmp(q, 16'h0000);
    summarize();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    summarize();
  end
endmodule

// [common/lse_pkg.sv]
// package: codes, offsets and types of the load/store/arith/logic exec unit
// Operation
// [RL1] extended index load copies memory into index
// [RL2] extended stores write register to operand address
// [RL3] immediate group found by fixed first-word pattern
// [RL4] immediate mode field zero, no address modification
// [RL5] immediate second word is data, loads copy it
// [RL6] immediate store writes second word, registers untouched
// [RL7] arithmetic code from bits 12-15 or 3-6
// [RL8] increment memory, overflow at max positive
// [RL9] immediate increment bumps second word in place
// [RL10] add to accumulator, signed overflow sets flag
// [RL11] immediate subtract uses literal like memory subtract
// [RL12] multiply-accumulate, high in acc, ext sign cleared
// [RL13] multiply overflow only on that corner case
// [RL14] extended/immediate multiply take other operand sources
// [RL15] divide acc:ext, quotient ext, remainder acc
// [RL16] divide flags invalid quotient, never small dividend
// [RL17] immediate/extended divide take other divisor sources
// [RL18] logic code from bits 12-15 or 3-6
// [RL19] inclusive-or operand into accumulator
// [RL20] exclusive-or operand into accumulator
// [RL21] and operand into accumulator
// [RL22] subtract in two's complement with overflow
// [RL23] normal/extended modify address, immediate never
package lse_pkg;
  localparam int          DW          = 16;       // data word width
  localparam int          AW          = 15;       // memory address width
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_WORD1   = 8'h08;
  localparam logic [7:0]  OFS_WORD2   = 8'h0C;
  localparam logic [7:0]  OFS_PADDR   = 8'h10;
  localparam logic [7:0]  OFS_ACC     = 8'h14;
  localparam logic [7:0]  OFS_EXT     = 8'h18;
  localparam logic [7:0]  OFS_IDX     = 8'h1C;
  // field positions
  localparam int          CTRL_GO     = 0;
  localparam int          ST_BUSY     = 0;
  localparam int          ST_OVF      = 1;
  localparam int          ST_FAULT    = 2;
  localparam logic [15:0] RST_WORD    = 16'h0000;  // value of data regs after reset
  // two-word prefix in bits 15-9, bits 8-7 zero
  localparam logic [6:0]  TWO_PAT     = 7'h06;
  // function codes
  localparam logic [3:0]  FN_LDA      = 4'h1;
  localparam logic [3:0]  FN_LDB      = 4'h2;
  localparam logic [3:0]  FN_LDX      = 4'h3;
  localparam logic [3:0]  FN_STA      = 4'h5;
  localparam logic [3:0]  FN_STB      = 4'h6;
  localparam logic [3:0]  FN_STX      = 4'h7;
  localparam logic [3:0]  FN_INC      = 4'h4;
  localparam logic [3:0]  FN_ADD      = 4'hA;
  localparam logic [3:0]  FN_SUB      = 4'hC;
  localparam logic [3:0]  FN_MUL      = 4'hE;
  localparam logic [3:0]  FN_DIV      = 4'hF;
  localparam logic [3:0]  FN_OR       = 4'h9;
  localparam logic [3:0]  FN_XOR      = 4'hB;
  localparam logic [3:0]  FN_AND      = 4'hD;
  // addressing modes
  localparam logic [2:0]  MODE_IMM    = 3'h0;
  localparam logic [2:0]  MODE_REL    = 3'h4;
  localparam logic [2:0]  MODE_XIX    = 3'h5;
  localparam logic [2:0]  MODE_BIX    = 3'h6;
  localparam logic [2:0]  MODE_IND    = 3'h7;
  localparam logic [15:0] MAX_POS     = 16'h7FFF;
  localparam logic [15:0] MOST_NEG    = 16'h8000;
  typedef enum logic [2:0] {S_IDLE, S_DECODE, S_IND, S_RD, S_EXEC, S_WR} lse_state_t;
  // memory request, held until ack
  typedef struct packed {
    logic          rd;
    logic          wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } lse_mem_req_t;
  // memory answer
  typedef struct packed {
    logic          ack;
    logic [DW-1:0] rdata;
  } lse_mem_rsp_t;
endpackage

// [rtl/lse_exec_unit.sv]
// exec unit for load/store, arithmetic and logic instructions
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module lse_exec_unit #(
  parameter int MAX_INDIRECT = 8  // pointer chain limit
) (
  input  wire logic                 REF_CLK,
  input  wire logic                 SRST,
  input  wire logic [7:0]           AVS_ADDRESS,
  input  wire logic                 AVS_READ,
  input  wire logic                 AVS_WRITE,
  input  wire logic [31:0]          AVS_WRITEDATA,
  input  wire logic [3:0]           AVS_BYTEENABLE,
  output logic [31:0]               AVS_READDATA,
  output logic                      AVS_WAITREQUEST,
  output lse_pkg::lse_mem_req_t     MEM_REQ,
  input  wire lse_pkg::lse_mem_rsp_t MEM_RSP,
  output logic                      BUSY,
  output logic                      OVERFLOW_FLAG
);
  import lse_pkg::*;

  // chain counter is 8 bits wide
  if (MAX_INDIRECT < 1 || MAX_INDIRECT > 255) begin : g_chk
    $error("MAX_INDIRECT must be 1..255");
  end

  lse_state_t        state_reg;    // sequencer state
  lse_mem_req_t      mem_req_reg;  // memory request
  logic [DW-1:0]     word1_reg;    // first instruction word
  logic [DW-1:0]     word2_reg;    // second instruction word
  logic [DW-1:0]     p_reg;        // location after first word
  logic [DW-1:0]     acc_reg;      // accumulator
  logic [DW-1:0]     ext_reg;      // extension register
  logic [DW-1:0]     idx_reg;      // index register
  logic [DW-1:0]     operand_reg;  // fetched or literal operand
  logic [AW-1:0]     ea_reg;       // effective address
  logic [7:0]        ind_cnt_reg;  // indirect steps taken
  logic              ovf_reg;      // sticky overflow
  logic              fault_reg;    // sticky decode/chain fault
  logic              busy_reg;     // instruction in flight
  logic              wait_reg;     // bus waitrequest
  logic [31:0]       rdata_reg;    // bus read data

  logic              two_word;     // two-word form
  logic [3:0]        fn_code;      // function code
  logic [2:0]        mode;         // addressing mode
  logic              is_imm;       // immediate form
  logic              is_store;     // store group
  logic              fn_known;     // code decodes
  logic [AW-1:0]     base_addr;    // address before indirection
  logic              ind_start;    // indirection requested
  logic [DW-1:0]     afield;       // one-word address field
  logic [DW-1:0]     store_val;    // register to store
  logic              idle;         // sequencer idle
  logic              exec_now;     // execute cycle
  logic              bus_wr;       // write completes this edge
  logic              go;           // start request
  logic              fault_evt;    // fault detected
  logic [31:0]       rd_mux;       // read data select
  logic [DW-1:0]     sum_w;        // acc plus operand
  logic [DW-1:0]     diff_w;       // acc minus operand
  logic [DW-1:0]     inc_w;        // operand plus one
  logic signed [31:0] op_sx;       // sign-extended operand
  logic signed [31:0] mul_full;    // operand*ext+acc
  logic signed [31:0] div_n;       // dividend acc:ext
  logic signed [31:0] div_d;       // divisor, never zero
  logic signed [31:0] div_q;       // full quotient
  logic signed [31:0] div_r;       // full remainder
  logic              div_bad;      // quotient invalid
  logic [DW-1:0]     res_acc;      // exec result acc
  logic [DW-1:0]     res_ext;      // exec result ext
  logic [DW-1:0]     res_idx;      // exec result idx
  logic [DW-1:0]     res_mem;      // exec result memory
  logic              res_ovf;      // exec overflow

  // byte-lane merge of a bus write into a 16-bit register
  function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] old_v);
    be_merge = {AVS_BYTEENABLE[1] ? AVS_WRITEDATA[15:8] : old_v[15:8],
                AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : old_v[7:0]};
  endfunction

  // memory request builder
  function automatic lse_mem_req_t mk_req(input logic rd, input logic wr,
                                          input logic [AW-1:0] addr,
                                          input logic [DW-1:0] wdata);
    mk_req = '{rd: rd, wr: wr, addr: addr, wdata: wdata};
  endfunction

  // instruction decode
  assign two_word = (word1_reg[15:9] == TWO_PAT) && (word1_reg[8:7] == 2'h0);  // RL3
  assign fn_code  = two_word ? word1_reg[6:3] : word1_reg[15:12];  // RL7 RL18 RL3
  assign mode     = two_word ? word1_reg[2:0] : word1_reg[11:9];
  assign is_imm   = two_word && (mode == MODE_IMM);  // RL4
  assign is_store = (fn_code == FN_STA) || (fn_code == FN_STB) || (fn_code == FN_STX);
  assign fn_known = (fn_code inside {FN_LDA, FN_LDB, FN_LDX, FN_STA, FN_STB, FN_STX,
                     FN_INC, FN_ADD, FN_SUB, FN_MUL, FN_DIV, FN_OR, FN_XOR, FN_AND});
  assign afield   = {7'h00, word1_reg[8:0]};
  assign idle     = (state_reg == S_IDLE);
  assign exec_now = (state_reg == S_EXEC);

  // operand address before indirection
  always_comb begin
    base_addr = '0;
    ind_start = 1'b0;
    if (two_word) begin
      ind_start = word2_reg[15];
      case (mode)
        MODE_REL: base_addr = AW'(word2_reg + p_reg);  // RL23
        MODE_XIX: base_addr = AW'(word2_reg + idx_reg);  // RL23
        MODE_BIX: base_addr = AW'(word2_reg + ext_reg);  // RL23
        default:  base_addr = word2_reg[AW-1:0];
      endcase
    end else begin
      case (mode)
        MODE_REL: base_addr = AW'(afield + p_reg);  // RL23
        MODE_XIX: base_addr = AW'(afield + idx_reg);  // RL23
        MODE_BIX: base_addr = AW'(afield + ext_reg);  // RL23
        MODE_IND: begin
          base_addr = afield[AW-1:0];
          ind_start = 1'b1;  // RL23
        end
        default:  base_addr = {4'h0, word1_reg[10:0]};
      endcase
    end
  end

  // register chosen by a store
  always_comb begin
    case (fn_code)
      FN_STB:  store_val = ext_reg;
      FN_STX:  store_val = idx_reg;
      default: store_val = acc_reg;
    endcase
  end

  // arithmetic datapath
  assign sum_w    = acc_reg + operand_reg;
  assign diff_w   = acc_reg - operand_reg;  // RL22
  assign inc_w    = operand_reg + 16'h0001;
  assign op_sx    = {{16{operand_reg[15]}}, operand_reg};
  assign mul_full = op_sx * {{16{ext_reg[15]}}, ext_reg}
                  + {{16{acc_reg[15]}}, acc_reg};  // RL12 RL14
  assign div_n    = {acc_reg[15], acc_reg, ext_reg[14:0]};  // RL15
  assign div_d    = (operand_reg == 16'h0000) ? 32'sh00000001 : op_sx;  // RL17
  assign div_q    = div_n / div_d;
  assign div_r    = div_n % div_d;
  assign div_bad  = (operand_reg == 16'h0000)
                  || (div_q[31:15] != {17{div_q[15]}});  // RL16

  // result select per function
  always_comb begin
    res_acc = acc_reg;
    res_ext = ext_reg;
    res_idx = idx_reg;
    res_mem = operand_reg;
    res_ovf = 1'b0;
    case (fn_code)
      FN_LDA: res_acc = operand_reg;  // RL5
      FN_LDB: res_ext = operand_reg;  // RL5
      FN_LDX: res_idx = operand_reg;  // RL1 RL5
      FN_INC: begin
        res_mem = inc_w;  // RL8 RL9
        res_ovf = (operand_reg == MAX_POS);  // RL8
      end
      FN_ADD: begin
        res_acc = sum_w;  // RL10
        res_ovf = (acc_reg[15] == operand_reg[15]) && (sum_w[15] != acc_reg[15]);  // RL10
      end
      FN_SUB: begin
        res_acc = diff_w;  // RL11 RL22
        res_ovf = (acc_reg[15] != operand_reg[15]) && (diff_w[15] != acc_reg[15]);  // RL22
      end
      FN_MUL: begin
        res_acc = mul_full[30:15];  // RL12
        res_ext = {1'b0, mul_full[14:0]};  // RL12
        res_ovf = (ext_reg == MOST_NEG) && (operand_reg == MOST_NEG) && !acc_reg[15];  // RL13
      end
      FN_DIV: begin
        res_acc = div_r[15:0];  // RL15
        res_ext = div_q[15:0];  // RL15
        res_ovf = div_bad;  // RL16
      end
      FN_OR:   res_acc = acc_reg | operand_reg;  // RL19
      FN_XOR:  res_acc = acc_reg ^ operand_reg;  // RL20
      FN_AND:  res_acc = acc_reg & operand_reg;  // RL21
      default: ;
    endcase
  end

  // bus strobes
  assign bus_wr = AVS_WRITE && !wait_reg;
  assign go     = bus_wr && idle && (AVS_ADDRESS == OFS_CTRL) && AVS_BYTEENABLE[0]
                  && AVS_WRITEDATA[CTRL_GO];
  assign fault_evt = ((state_reg == S_DECODE) && !fn_known)
                   || ((state_reg == S_IND) && MEM_RSP.ack && MEM_RSP.rdata[15]
                       && (ind_cnt_reg >= 8'(MAX_INDIRECT)));

  // read data select, unmapped reads zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (AVS_ADDRESS)
      OFS_STATUS: rd_mux[2:0] = {fault_reg, ovf_reg, busy_reg};
      OFS_WORD1:  rd_mux[15:0] = word1_reg;
      OFS_WORD2:  rd_mux[15:0] = word2_reg;
      OFS_PADDR:  rd_mux[15:0] = p_reg;
      OFS_ACC:    rd_mux[15:0] = acc_reg;
      OFS_EXT:    rd_mux[15:0] = ext_reg;
      OFS_IDX:    rd_mux[15:0] = idx_reg;
      default:    ;
    endcase
  end

  // bus slave: one wait cycle, then answer
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else if ((AVS_READ || AVS_WRITE) && wait_reg) begin
      wait_reg  <= 1'b0;
      rdata_reg <= AVS_READ ? rd_mux : 32'h00000000;
    end else begin
      wait_reg  <= 1'b1;
    end
  end

  // instruction words, writable while idle
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      word1_reg <= RST_WORD;
      word2_reg <= RST_WORD;
      p_reg     <= RST_WORD;
    end else if (bus_wr && idle) begin
      if (AVS_ADDRESS == OFS_WORD1) word1_reg <= be_merge(word1_reg);
      if (AVS_ADDRESS == OFS_WORD2) word2_reg <= be_merge(word2_reg);
      if (AVS_ADDRESS == OFS_PADDR) p_reg <= be_merge(p_reg);
    end
  end

  // processor registers: exec result or bus write
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      acc_reg <= RST_WORD;
      ext_reg <= RST_WORD;
      idx_reg <= RST_WORD;
    end else if (exec_now) begin
      acc_reg <= res_acc;
      ext_reg <= res_ext;
      idx_reg <= res_idx;
    end else if (bus_wr && idle) begin
      if (AVS_ADDRESS == OFS_ACC) acc_reg <= be_merge(acc_reg);
      if (AVS_ADDRESS == OFS_EXT) ext_reg <= be_merge(ext_reg);
      if (AVS_ADDRESS == OFS_IDX) idx_reg <= be_merge(idx_reg);
    end
  end

  // sticky overflow, set beats clear
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ovf_reg <= 1'b0;
    end else if (exec_now && res_ovf) begin
      ovf_reg <= 1'b1;  // RL8 RL10 RL13 RL16
    end else if (bus_wr && (AVS_ADDRESS == OFS_STATUS) && AVS_BYTEENABLE[0]
                 && AVS_WRITEDATA[ST_OVF]) begin
      ovf_reg <= 1'b0;
    end
  end

  // sticky fault, set beats clear
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      fault_reg <= 1'b0;
    end else if (fault_evt) begin
      fault_reg <= 1'b1;
    end else if (bus_wr && (AVS_ADDRESS == OFS_STATUS) && AVS_BYTEENABLE[0]
                 && AVS_WRITEDATA[ST_FAULT]) begin
      fault_reg <= 1'b0;
    end
  end

  // sequencer and memory requests
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_reg   <= S_IDLE;
      mem_req_reg <= '0;
      operand_reg <= RST_WORD;
      ea_reg      <= '0;
      ind_cnt_reg <= 8'h00;
      busy_reg    <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (go) begin
            state_reg <= S_DECODE;
            busy_reg  <= 1'b1;
          end
        end
        S_DECODE: begin
          ind_cnt_reg <= 8'h00;
          if (!fn_known) begin
            state_reg <= S_IDLE;
            busy_reg  <= 1'b0;
          end else if (is_imm) begin
            // literal path: no address arithmetic at all
            ea_reg      <= p_reg[AW-1:0];  // RL4 RL9
            operand_reg <= word2_reg;  // RL5 RL11 RL14 RL17 RL19
            if (is_store) begin
              mem_req_reg <= mk_req(1'b0, 1'b1, p_reg[AW-1:0], store_val);  // RL6
              state_reg   <= S_WR;
            end else begin
              state_reg   <= S_EXEC;
            end
          end else if (ind_start) begin
            mem_req_reg <= mk_req(1'b1, 1'b0, base_addr, RST_WORD);  // RL23
            state_reg   <= S_IND;
          end else if (is_store) begin
            ea_reg      <= base_addr;
            mem_req_reg <= mk_req(1'b0, 1'b1, base_addr, store_val);  // RL2
            state_reg   <= S_WR;
          end else begin
            ea_reg      <= base_addr;
            mem_req_reg <= mk_req(1'b1, 1'b0, base_addr, RST_WORD);  // RL1 RL14 RL17
            state_reg   <= S_RD;
          end
        end
        S_IND: begin
          if (MEM_RSP.ack) begin
            if (MEM_RSP.rdata[15] && (ind_cnt_reg < 8'(MAX_INDIRECT))) begin
              // chain continues through another pointer
              mem_req_reg <= mk_req(1'b1, 1'b0, MEM_RSP.rdata[AW-1:0], RST_WORD);
              ind_cnt_reg <= ind_cnt_reg + 8'h01;
            end else if (MEM_RSP.rdata[15]) begin
              mem_req_reg <= '0;
              state_reg   <= S_IDLE;
              busy_reg    <= 1'b0;
            end else if (is_store) begin
              ea_reg      <= MEM_RSP.rdata[AW-1:0];
              mem_req_reg <= mk_req(1'b0, 1'b1, MEM_RSP.rdata[AW-1:0], store_val);  // RL2
              state_reg   <= S_WR;
            end else begin
              ea_reg      <= MEM_RSP.rdata[AW-1:0];
              mem_req_reg <= mk_req(1'b1, 1'b0, MEM_RSP.rdata[AW-1:0], RST_WORD);
              state_reg   <= S_RD;
            end
          end
        end
        S_RD: begin
          if (MEM_RSP.ack) begin
            mem_req_reg <= '0;
            operand_reg <= MEM_RSP.rdata;
            state_reg   <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (fn_code == FN_INC) begin
            mem_req_reg <= mk_req(1'b0, 1'b1, ea_reg, res_mem);  // RL8 RL9
            state_reg   <= S_WR;
          end else begin
            state_reg   <= S_IDLE;
            busy_reg    <= 1'b0;
          end
        end
        S_WR: begin
          if (MEM_RSP.ack) begin
            mem_req_reg <= '0;
            state_reg   <= S_IDLE;
            busy_reg    <= 1'b0;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  assign AVS_READDATA    = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;
  assign MEM_REQ         = mem_req_reg;
  assign BUSY            = busy_reg;
  assign OVERFLOW_FLAG   = ovf_reg;

  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  property p_idx_load;
    exec_now && !is_imm && (fn_code == FN_LDX) |=> idx_reg == $past(operand_reg)
      && $stable(acc_reg);
  endproperty
  a_idx_load: assert property (p_idx_load) // RL1
    else $error("index load wrong");

  property p_store_acc;
    mem_req_reg.wr && !is_imm && (fn_code == FN_STA) |-> mem_req_reg.wdata == acc_reg;
  endproperty
  a_store_acc: assert property (p_store_acc) // RL2
    else $error("stored data is not acc");

  property p_imm_literal;
    (state_reg == S_DECODE) && is_imm && fn_known && !is_store
      |=> operand_reg == $past(word2_reg) && (state_reg == S_EXEC) && !mem_req_reg.rd;
  endproperty
  a_imm_literal: assert property (p_imm_literal) // RL5
    else $error("immediate operand not literal");

  property p_imm_store;
    mem_req_reg.wr && is_imm && is_store |-> mem_req_reg.addr == p_reg[AW-1:0]
      && $stable(acc_reg) && $stable(ext_reg) && $stable(idx_reg);
  endproperty
  a_imm_store: assert property (p_imm_store) // RL6
    else $error("immediate store misplaced");

  property p_inc_wrap;
    exec_now && (fn_code == FN_INC) && (operand_reg == MAX_POS)
      |=> ovf_reg && mem_req_reg.wr && (mem_req_reg.wdata == MOST_NEG);
  endproperty
  a_inc_wrap: assert property (p_inc_wrap) // RL8
    else $error("increment overflow wrong");

  property p_add_sum;
    exec_now && (fn_code == FN_ADD) |=> acc_reg == $past(sum_w);
  endproperty
  a_add_sum: assert property (p_add_sum) // RL10
    else $error("add result wrong");

  property p_mul_sign;
    exec_now && (fn_code == FN_MUL) |=> !ext_reg[15] ##1 !ext_reg[15] || busy_reg;
  endproperty
  a_mul_sign: assert property (p_mul_sign) // RL12
    else $error("ext sign not cleared");

  property p_mul_ovf;
    exec_now && (fn_code == FN_MUL) && !ovf_reg
      && ((ext_reg != MOST_NEG) || (operand_reg != MOST_NEG) || acc_reg[15]) |=> !ovf_reg;
  endproperty
  a_mul_ovf: assert property (p_mul_ovf) // RL13
    else $error("spurious multiply overflow");

  property p_div_small;
    exec_now && (fn_code == FN_DIV) && !ovf_reg && !acc_reg[15] && !operand_reg[15]
      && ({16'h0000, operand_reg} > div_n) |=> !ovf_reg && (ext_reg == 16'h0000)
      && (acc_reg == {$past(acc_reg[0]), $past(ext_reg[14:0])});
  endproperty
  a_div_small: assert property (p_div_small) // RL16
    else $error("divide overflow on small dividend");

  property p_or_acc;
    exec_now && (fn_code == FN_OR) |=> acc_reg == ($past(acc_reg) | $past(operand_reg));
  endproperty
  a_or_acc: assert property (p_or_acc) // RL19
    else $error("inclusive-or wrong");

  property p_bus_answer;
    (AVS_READ || AVS_WRITE) |-> ##[0:1] !AVS_WAITREQUEST;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer late");

  c_mul: cover property (exec_now && (fn_code == FN_MUL));
  c_div_bad: cover property (exec_now && (fn_code == FN_DIV) && div_bad);
  c_inc_wrap: cover property (exec_now && (fn_code == FN_INC) && (operand_reg == MAX_POS));
  c_imm_store: cover property (mem_req_reg.wr && is_imm);
endmodule
